// *** src/pdm_regs.vh ***
// Register map, field positions, reset values and timing counts of the power-down control.
// Summary of operation
// RULE_01 - Low-power instruction with select clear enters sleep
// RULE_02 - Low-power instruction with select set enters standby
// RULE_03 - Select bit stays set after interrupt wake
// RULE_04 - Three-bit code picks settling wait length
// RULE_05 - Software picks a wait of 7 ms
// RULE_06 - Keep bit clear floats bus pins in standby
// RULE_07 - Keep bit set holds address, strobes high
// RULE_08 - Module stop high resets to 0x78
// RULE_09 - Clock output stop bit gates clock pin
// RULE_10 - Bits six to three read one always
// RULE_11 - Bit two stores and returns written value
// RULE_12 - Bit one puts serial channel 1 to standby
// RULE_13 - Bit zero puts serial channel 0 to standby
// RULE_14 - Stopped module has its registers reset
// RULE_15 - Software clears stop bit before reprogramming module
// RULE_16 - Software clears RAM enable before hardware standby
// RULE_17 - Sleep halts only the CPU
// RULE_18 - Software standby halts clock, CPU, resets peripherals
// RULE_19 - Interrupt wake waits settling count, then resumes
// RULE_20 - Standby pin low forces hardware standby
// RULE_21 - Reset pin low forces reset state
`ifndef PDM_REGS_VH
`define PDM_REGS_VH
`define PDM_ADDR_W 22
`define PDM_IDX_SYSCTL 20'hee012
`define PDM_IDX_MSTOPH 20'hee01c
`define PDM_IDX_MSTOPL 20'hee01d
`define PDM_RST_SYSCTL 8'h09
`define PDM_RST_MSTOPH 8'h78
`define PDM_RST_MSTOPL 8'h00
`define PDM_MSTOPH_ONES 8'h78
`define PDM_BIT_SSEL 7
`define PDM_BIT_STS_HI 6
`define PDM_BIT_STS_LO 4
`define PDM_BIT_KEEP 1
`define PDM_BIT_ONCHIP_RAM_ENABLE 0
`define PDM_BIT_CLKSTOP 7
`define PDM_BIT_RSVD2 2
`define PDM_BIT_SER1 1
`define PDM_BIT_SER0 0
`define PDM_SETTLE_C0 19'd8192
`define PDM_SETTLE_C1 19'd16384
`define PDM_SETTLE_C2 19'd32768
`define PDM_SETTLE_C3 19'd65536
`define PDM_SETTLE_C4 19'd131072
`define PDM_SETTLE_C5 19'd262144
`define PDM_SETTLE_C6 19'd1024
`define PDM_RESP_OKAY 2'b00
`define PDM_RESP_SLVERR 2'b10
`endif

// *** src/pdm_ctrl.v ***
// Power-down mode control with its AXI4-Lite register slave.
`timescale 1ns/1ps
`include "pdm_regs.vh"
module pdm_ctrl #(
    parameter [18:0] SETTLE_C0 = `PDM_SETTLE_C0,
    parameter [18:0] SETTLE_C1 = `PDM_SETTLE_C1,
    parameter [18:0] SETTLE_C2 = `PDM_SETTLE_C2,
    parameter [18:0] SETTLE_C3 = `PDM_SETTLE_C3,
    parameter [18:0] SETTLE_C4 = `PDM_SETTLE_C4,
    parameter [18:0] SETTLE_C5 = `PDM_SETTLE_C5
) (
    input wire aclk,
    input wire aresetn,
    input wire [`PDM_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`PDM_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sleep_req,
    input wire ext_irq,
    input wire hw_standby_pin_n,
    input wire chip_init_pin_n,
    output reg cpu_halt,
    output reg clock_halt,
    output reg sleep_mode,
    output reg sw_standby,
    output reg hw_standby,
    output reg wake_irq_start,
    output reg sysclk_out_en,
    output reg serial0_stop,
    output reg serial1_stop,
    output reg serial0_reset,
    output reg serial1_reset,
    output reg periph_reset,
    output reg addr_out_en,
    output reg ctrl_out_en,
    output reg ctrl_force_high,
    output reg onchip_ram_enable,
    output reg [7:0] module_stop_low
);
    localparam [2:0] ST_RUN = 3'd0;
    localparam [2:0] ST_SLEEP = 3'd1;
    localparam [2:0] ST_SWSTBY = 3'd2;
    localparam [2:0] ST_SETTLE = 3'd3;
    localparam [2:0] ST_HWSTBY = 3'd4;
    localparam [1:0] SEL_NONE = 2'd0;
    localparam [1:0] SEL_SYS = 2'd1;
    localparam [1:0] SEL_MSH = 2'd2;
    localparam [1:0] SEL_MSL = 2'd3;
    localparam [7:0] MSTOPH_RST = `PDM_RST_MSTOPH;

    // Printed offsets are word indices; the byte address is four times the index.
    function [1:0] reg_sel;
        input [`PDM_ADDR_W-1:0] addr;
        begin
            if (addr[1:0] != 2'b00) begin
                reg_sel = SEL_NONE;
            end else if (addr[`PDM_ADDR_W-1:2] == `PDM_IDX_SYSCTL) begin
                reg_sel = SEL_SYS;
            end else if (addr[`PDM_ADDR_W-1:2] == `PDM_IDX_MSTOPH) begin
                reg_sel = SEL_MSH;
            end else if (addr[`PDM_ADDR_W-1:2] == `PDM_IDX_MSTOPL) begin
                reg_sel = SEL_MSL;
            end else begin
                reg_sel = SEL_NONE;
            end
        end
    endfunction

    function [18:0] settle_len;
        input [2:0] code;
        begin
            case (code)
                3'd0: settle_len = SETTLE_C0;
                3'd1: settle_len = SETTLE_C1;
                3'd2: settle_len = SETTLE_C2;
                3'd3: settle_len = SETTLE_C3;
                3'd4: settle_len = SETTLE_C4;
                3'd5: settle_len = SETTLE_C5;
                3'd6: settle_len = `PDM_SETTLE_C6;
                default: settle_len = SETTLE_C5;
            endcase
        end
    endfunction

    reg [2:0] sync1_ff;
    reg [2:0] sync2_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [18:0] settle_cnt_ff;
    reg [7:0] sysctl_ff;
    reg [3:0] mstoph_ff;
    reg aw_held_ff;
    reg w_held_ff;
    reg [`PDM_ADDR_W-1:0] awaddr_ff;
    reg [7:0] wdata_ff;
    reg wlane_ff;
    wire irq_s;
    wire hwstby_s;
    wire init_s;
    wire reg_init;
    wire do_write;
    wire [1:0] wsel;
    wire [7:0] mstoph_rd;
    wire keep;

    // Pins are synchronised: ext_irq, standby pin low, reset pin low.
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= 3'b000;
            sync2_ff <= 3'b000;
        end else begin
            sync1_ff <= {!chip_init_pin_n, !hw_standby_pin_n, ext_irq};
            sync2_ff <= sync1_ff;
        end
    end
    assign irq_s = sync2_ff[0];
    assign hwstby_s = sync2_ff[1];
    assign init_s = sync2_ff[2];
    assign reg_init = init_s || hwstby_s; // RULE_08 RULE_21
    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wsel = reg_sel(awaddr_ff);
    assign mstoph_rd = {mstoph_ff[3], 4'hf, mstoph_ff[2:0]}; // RULE_10
    assign keep = sysctl_ff[`PDM_BIT_KEEP];

    // Mode sequencing.
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (sleep_req) begin
                    if (sysctl_ff[`PDM_BIT_SSEL]) begin
                        nxt_state = ST_SWSTBY; // RULE_02
                    end else begin
                        nxt_state = ST_SLEEP; // RULE_01
                    end
                end
            end
            ST_SLEEP: begin
                if (irq_s) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_SWSTBY: begin
                if (irq_s) begin
                    nxt_state = ST_SETTLE; // RULE_19
                end
            end
            ST_SETTLE: begin
                if (settle_cnt_ff == 19'd0) begin
                    nxt_state = ST_RUN; // RULE_19
                end
            end
            ST_HWSTBY: begin
                nxt_state = ST_RUN;
            end
            default: nxt_state = ST_RUN;
        endcase
        if (hwstby_s) begin
            nxt_state = ST_HWSTBY; // RULE_20
        end else if (init_s) begin
            nxt_state = ST_RUN; // RULE_21
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_RUN;
            settle_cnt_ff <= 19'd0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff != ST_SETTLE) begin
                settle_cnt_ff <= settle_len(sysctl_ff[`PDM_BIT_STS_HI:`PDM_BIT_STS_LO]) - 19'd1; // RULE_04
            end else if (settle_cnt_ff != 19'd0) begin
                settle_cnt_ff <= settle_cnt_ff - 19'd1;
            end
        end
    end

    // Registers are not touched by software standby, only by reset or hardware standby.
    always @(posedge aclk) begin
        if (!aresetn || reg_init) begin
            sysctl_ff <= `PDM_RST_SYSCTL;
            mstoph_ff <= {MSTOPH_RST[7], MSTOPH_RST[2:0]}; // RULE_08
            module_stop_low <= `PDM_RST_MSTOPL;
        end else if (do_write && wlane_ff) begin
            if (wsel == SEL_SYS) begin
                sysctl_ff <= wdata_ff; // RULE_03
            end
            if (wsel == SEL_MSH) begin
                mstoph_ff <= {wdata_ff[7], wdata_ff[2:0]}; // RULE_09 RULE_11 RULE_12 RULE_13
            end
            if (wsel == SEL_MSL) begin
                module_stop_low <= wdata_ff;
            end
        end
    end

    // Write channel: address and data are taken in either order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PDM_RESP_OKAY;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= {`PDM_ADDR_W{1'b0}};
            wdata_ff <= 8'h00;
            wlane_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata[7:0];
                wlane_ff <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wsel == SEL_NONE) ? `PDM_RESP_SLVERR : `PDM_RESP_OKAY;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PDM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PDM_RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                SEL_SYS: s_axi_rdata <= {24'h000000, sysctl_ff};
                SEL_MSH: s_axi_rdata <= {24'h000000, mstoph_rd};
                SEL_MSL: s_axi_rdata <= {24'h000000, module_stop_low};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `PDM_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Mode outputs are registered from the next state so they align with state_ff.
    always @(posedge aclk) begin
        if (!aresetn) begin
            cpu_halt <= 1'b0;
            clock_halt <= 1'b0;
            sleep_mode <= 1'b0;
            sw_standby <= 1'b0;
            hw_standby <= 1'b0;
            wake_irq_start <= 1'b0;
            periph_reset <= 1'b0;
            sysclk_out_en <= 1'b1;
            serial0_stop <= 1'b0;
            serial1_stop <= 1'b0;
            serial0_reset <= 1'b0;
            serial1_reset <= 1'b0;
            addr_out_en <= 1'b1;
            ctrl_out_en <= 1'b1;
            ctrl_force_high <= 1'b0;
            onchip_ram_enable <= 1'b1;
        end else begin
            sleep_mode <= (nxt_state == ST_SLEEP);
            cpu_halt <= (nxt_state != ST_RUN); // RULE_17
            clock_halt <= (nxt_state == ST_SWSTBY) || (nxt_state == ST_SETTLE) ||
                (nxt_state == ST_HWSTBY); // RULE_18
            sw_standby <= (nxt_state == ST_SWSTBY) || (nxt_state == ST_SETTLE);
            hw_standby <= (nxt_state == ST_HWSTBY);
            wake_irq_start <= (state_ff == ST_SETTLE) && (nxt_state == ST_RUN); // RULE_19
            periph_reset <= (nxt_state == ST_SWSTBY) || (nxt_state == ST_SETTLE) ||
                (nxt_state == ST_HWSTBY); // RULE_18
            sysclk_out_en <= !mstoph_ff[3] && (nxt_state != ST_HWSTBY); // RULE_09
            serial0_stop <= mstoph_ff[0]; // RULE_13
            serial1_stop <= mstoph_ff[1]; // RULE_12
            serial0_reset <= mstoph_ff[0] || (nxt_state != ST_RUN && nxt_state != ST_SLEEP); // RULE_14
            serial1_reset <= mstoph_ff[1] || (nxt_state != ST_RUN && nxt_state != ST_SLEEP); // RULE_14
            onchip_ram_enable <= sysctl_ff[`PDM_BIT_ONCHIP_RAM_ENABLE];
            if (nxt_state == ST_HWSTBY) begin
                addr_out_en <= 1'b0;
                ctrl_out_en <= 1'b0;
                ctrl_force_high <= 1'b0;
            end else if (nxt_state == ST_SWSTBY || nxt_state == ST_SETTLE) begin
                addr_out_en <= keep; // RULE_06 RULE_07
                ctrl_out_en <= keep; // RULE_06 RULE_07
                ctrl_force_high <= keep; // RULE_07
            end else begin
                addr_out_en <= 1'b1;
                ctrl_out_en <= 1'b1;
                ctrl_force_high <= 1'b0;
            end
        end
    end
endmodule

// *** tb/pdm_ctrl_monitor.sv ***
// Port checker for the power-down mode control.
`timescale 1ns/1ps
module pdm_ctrl_monitor (
    input wire aclk,
    input wire aresetn,
    input wire sleep_req,
    input wire cpu_halt,
    input wire clock_halt,
    input wire sleep_mode,
    input wire sw_standby,
    input wire hw_standby,
    input wire wake_irq_start,
    input wire sysclk_out_en,
    input wire serial0_stop,
    input wire serial1_stop,
    input wire serial0_reset,
    input wire serial1_reset,
    input wire periph_reset,
    input wire addr_out_en,
    input wire ctrl_out_en,
    input wire ctrl_force_high
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_SLEEP: assert property (sleep_req && !cpu_halt |=> sleep_mode ^ sw_standby)
        else $error("low-power request entered no single mode");
    AST_NAP: assert property (sleep_mode |-> cpu_halt && !clock_halt)
        else $error("sleep halts more than the processor");
    AST_SWSTBY: assert property (sw_standby |-> clock_halt && periph_reset && serial0_reset
        && serial1_reset)
        else $error("standby left clock or peripherals running");
    AST_FORCE: assert property (ctrl_force_high |-> sw_standby && addr_out_en && ctrl_out_en)
        else $error("strobes forced high outside standby");
    AST_RUNBUS: assert property (!sw_standby && !hw_standby |-> addr_out_en && ctrl_out_en
        && !ctrl_force_high)
        else $error("bus pins not driven in run");
    AST_WAKE: assert property ($rose(wake_irq_start) |-> ##[0:1] !sw_standby && !clock_halt)
        else $error("wake pulse without resuming the clock");
    AST_SER0: assert property (serial0_stop |-> serial0_reset)
        else $error("stopped channel 0 not held in reset");
    AST_SER1: assert property (serial1_stop |-> serial1_reset)
        else $error("stopped channel 1 not held in reset");
    AST_HWSTBY: assert property (hw_standby |-> clock_halt && cpu_halt && !sysclk_out_en
        && !addr_out_en && !ctrl_out_en)
        else $error("hardware standby left outputs active");
    COV_SLEEP: cover property ($rose(sleep_mode));
    COV_WAKE: cover property (wake_irq_start);
    COV_FORCE: cover property ($rose(ctrl_force_high));
    COV_HW: cover property ($rose(hw_standby));
endmodule
bind pdm_ctrl pdm_ctrl_monitor mon_u (.aclk, .aresetn, .sleep_req, .cpu_halt, .clock_halt,
    .sleep_mode, .sw_standby, .hw_standby, .wake_irq_start, .sysclk_out_en, .serial0_stop,
    .serial1_stop, .serial0_reset, .serial1_reset, .periph_reset, .addr_out_en, .ctrl_out_en,
    .ctrl_force_high);

// *** tb/power_down_mode_control_tb.sv ***
// Self-checking bench of the power-down mode control.
`timescale 1ns/1ps
`include "pdm_regs.vh"
module power_down_mode_control_tb;
    localparam [21:0] A_SYS = 22'h3b8048;
    localparam [21:0] A_MSH = 22'h3b8070;
    localparam [21:0] A_MSL = 22'h3b8074;
    reg aclk = 1'b0, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    reg s_axi_rready, sleep_req, ext_irq, hw_standby_pin_n, chip_init_pin_n;
    reg [21:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata;
    reg [3:0] s_axi_wstrb;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire cpu_halt, clock_halt, sleep_mode, sw_standby, hw_standby, wake_irq_start;
    wire sysclk_out_en, serial0_stop, serial1_stop, serial0_reset, serial1_reset;
    wire periph_reset, addr_out_en, ctrl_out_en, ctrl_force_high, onchip_ram_enable;
    wire [7:0] module_stop_low;
    int n_errors = 0, comparisons = 0, i, c, n;
    int nw [0:7] = '{8192, 16, 32, 64, 128, 256, 1024, 256};
    reg [1:0] r;
    reg [31:0] d;
    reg [42:0] rw;
    // Row: address, write byte, read byte, response, {serial1, serial0, clock out enable}.
    reg [42:0] rows [0:4] = '{{A_MSH, 8'h00, 8'h78, 2'b00, 3'b001},
        {A_MSH, 8'h87, 8'hff, 2'b00, 3'b110}, {A_MSH, 8'h02, 8'h7a, 2'b00, 3'b101},
        {A_MSL, 8'ha5, 8'ha5, 2'b00, 3'b101}, {22'h3b804c, 8'h5a, 8'h00, 2'b10, 3'b101}};
    always #10 aclk = ~aclk;
    pdm_ctrl #(.SETTLE_C1(16), .SETTLE_C2(32), .SETTLE_C3(64), .SETTLE_C4(128),
        .SETTLE_C5(256)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sleep_req, .ext_irq, .hw_standby_pin_n, .chip_init_pin_n,
        .cpu_halt, .clock_halt, .sleep_mode, .sw_standby, .hw_standby, .wake_irq_start,
        .sysclk_out_en, .serial0_stop, .serial1_stop, .serial0_reset, .serial1_reset,
        .periph_reset, .addr_out_en, .ctrl_out_en, .ctrl_force_high, .onchip_ram_enable,
        .module_stop_low);
    task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task give_verdict;
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input [21:0] a, input [7:0] v, output [1:0] rs);
        reg aw, w;
        aw = 1;
        w = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 0;
                s_axi_awvalid <= 0;
            end
            if (w && s_axi_wready) begin
                w = 0;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
    endtask
    task rd(input [21:0] a, output [31:0] v, output [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task slp;
        @(posedge aclk);
        sleep_req <= 1;
        @(posedge aclk);
        sleep_req <= 0;
        @(posedge aclk);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sleep_req, ext_irq} <= 0;
        {s_axi_bready, s_axi_rready, hw_standby_pin_n, chip_init_pin_n} <= 4'hf;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 0;
        s_axi_wstrb <= 4'h1;
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(A_SYS, d, r);
        chk(d, 32'h09, "sysctl");
        rd(A_MSH, d, r);
        chk(d, 32'h78, "mstoph");
        chk(sysclk_out_en, 1, "clkout");
        for (i = 0; i < 5; i++) begin
            rw = rows[i];
            wr(rw[42:21], rw[20:13], r);
            chk(r, rw[4:3], "bresp");
            rd(rw[42:21], d, r);
            chk(d, {24'h0, rw[12:5]}, "rdata");
            chk(r, rw[4:3], "rresp");
            chk({serial1_stop, serial0_stop, sysclk_out_en}, rw[2:0], "stops");
        end
        chk(module_stop_low, 32'ha5, "mstopl");
        s_axi_wstrb <= 4'h0;
        wr(A_MSL, 8'h3c, r);
        s_axi_wstrb <= 4'h1;
        chk(r, 0, "bresp masked");
        rd(A_MSL, d, r);
        chk(d, 32'ha5, "masked write");
        wr(A_SYS, 8'h09, r);
        slp;
        chk({sleep_mode, sw_standby, cpu_halt, clock_halt}, 4'b1010, "sleep");
        ext_irq <= 1;
        repeat (6) @(posedge aclk);
        ext_irq <= 0;
        chk(sleep_mode, 0, "sleep exit");
        for (c = 0; c < 8; c++) begin
            wr(A_SYS, {1'b1, c[2:0], 2'b10, c[0], 1'b1}, r);
            slp;
            chk(sw_standby, 1, "standby");
            chk({addr_out_en, ctrl_out_en, ctrl_force_high}, {3{c[0]}}, "bus pins");
            ext_irq <= 1;
            n = 0;
            while (wake_irq_start !== 1'b1 && n < 9000) begin
                @(posedge aclk);
                n++;
            end
            ext_irq <= 0;
            chk(n >= nw[c] && n <= nw[c] + 6, 1, "settle");
            rd(A_SYS, d, r);
            chk(d[7], 1, "select kept");
        end
        wr(A_SYS, 8'h08, r);
        @(posedge aclk);
        chk(onchip_ram_enable, 0, "ram enable");
        hw_standby_pin_n <= 0;
        repeat (6) @(posedge aclk);
        chk({hw_standby, sysclk_out_en, addr_out_en, ctrl_out_en}, 0 | 4'b1000, "hwstby");
        hw_standby_pin_n <= 1;
        repeat (6) @(posedge aclk);
        rd(A_MSH, d, r);
        chk(d, 32'h78, "mstoph");
        chk(onchip_ram_enable, 1, "ram reinit");
        wr(A_MSH, 8'h03, r);
        slp;
        chip_init_pin_n <= 0;
        repeat (6) @(posedge aclk);
        chip_init_pin_n <= 1;
        repeat (6) @(posedge aclk);
        chk({sleep_mode, serial1_stop, serial0_stop}, 0, "init");
        wr(A_MSH, 8'h81, r);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk({sysclk_out_en, serial0_stop, s_axi_bvalid}, 3'b100, "reset");
        rd(A_MSH, d, r);
        chk(d, 32'h78, "mstoph reset");
        give_verdict;
    end
    initial begin
        #1000000;
        n_errors++;
        give_verdict;
    end
endmodule
